// ### include/nav_pkg.sv
/*
 * Shared constants, types and helpers for the navigation packet framer:
 * header layout, identifier classes, acknowledgement codes, CRC setup
 * and output timing.
 * Assumes a 200 MHz system clock and a byte-wide serial link on each side.
 */
// Notes on behaviour
// RQ1 - a packet is five header bytes (check, id, length, crc) then payload
// RQ2 - check byte is ((id + len + crc low + crc high) xor ff) + 1
// RQ3 - receiver finds packet starts by scanning for a valid check byte
// RQ4 - ids 0-19 system, 20-179 state, 180-255 configuration
// RQ5 - length counts payload bytes only, from byte 5, range 0 to 255
// RQ6 - crc16-ccitt seeded ffff over payload bytes only
// RQ7 - state and config packets are sent on request at any time
// RQ8 - configuration packets get an acknowledgement with the outcome
// RQ9 - external data packets are acknowledged only when they fail
// RQ10 - system state and raw sensor packets go out at 20 Hz by default
// RQ11 - packets due together leave back to back, lowest id first
// RQ12 - all packets of one output sequence share one time of validity
// RQ13 - multi-byte fields go least significant byte first
// RQ14 - payload fields are 1, 2, 4 or 8 bytes wide by type
// RQ15 - host picks a baud rate at least 11 times the byte throughput
// RQ16 - request packet id 1, one requested id per payload byte
// RQ17 - acknowledgement is id 0 with id, crc, result code payload
// RQ18 - codes 0 ok, 1 crc, 2 size, 3 range, 4 flash, 5 busy, 6 unknown
// RQ19 - crc polynomial 1021, msb first, no reflection, no final xor
// RQ20 - bad check slips one byte; bad crc drops packet, acks crc error (code acks config ids only, and none while an ack is pending)
package nav_pkg;
  localparam int HDR_BYTES = 5; // [RQ1]
  localparam int OFS_LRC = 0;
  localparam int OFS_ID = 1;
  localparam int OFS_LEN = 2;
  localparam int OFS_CRC_LO = 3; // [RQ13]
  localparam int OFS_CRC_HI = 4;
  localparam logic [7:0] LRC_XOR = 8'hff;
  localparam logic [7:0] SYS_MAX = 8'h13; // [RQ4]
  localparam logic [7:0] STATE_MIN = 8'h14;
  localparam logic [7:0] STATE_MAX = 8'hb3;
  localparam logic [7:0] CFG_MIN = 8'hb4;
  localparam logic [7:0] ACK_ID = 8'h00; // [RQ17]
  localparam logic [7:0] REQ_ID = 8'h01; // [RQ16]
  localparam logic [7:0] ACK_LEN = 8'h04;
  localparam logic [7:0] RES_OK = 8'h00; // [RQ18]
  localparam logic [7:0] RES_CRC = 8'h01;
  localparam logic [7:0] RES_SIZE = 8'h02;
  localparam logic [7:0] RES_RANGE = 8'h03;
  localparam logic [7:0] RES_FLASH = 8'h04;
  localparam logic [7:0] RES_BUSY = 8'h05;
  localparam logic [7:0] RES_UNKNOWN = 8'h06;
  localparam logic [15:0] CRC_INIT = 16'hffff; // [RQ6]
  localparam logic [15:0] CRC_POLY = 16'h1021; // [RQ19]
  // payload field widths in bytes by type [RQ14]
  localparam int W_INT8 = 1;
  localparam int W_INT16 = 2;
  localparam int W_INT32 = 4;
  localparam int W_FLOAT = 4;
  localparam int W_INT64 = 8;
  localparam int W_DOUBLE = 8;
  localparam int MAX_PAYLOAD = 255; // [RQ5]
  localparam int CLK_HZ = 200_000_000;
  localparam int OUT_RATE_HZ = 20; // [RQ10]
  localparam int PERIOD_CYCLES = CLK_HZ / OUT_RATE_HZ;
  localparam logic [7:0] SYS_STATE_ID_DEF = 8'h14;
  localparam logic [7:0] RAW_SENSOR_ID_DEF = 8'h1c;

  typedef enum logic [1:0] {CLS_SYSTEM, CLS_STATE, CLS_CONFIG} id_class_t;

  typedef struct packed {
    logic [7:0] id;
    logic [7:0] len;
    logic [15:0] crc;
  } hdr_t;

  typedef struct packed {
    logic [7:0] id;
    logic [15:0] crc;
    logic [7:0] code;
  } ack_t;

  function automatic logic [7:0] lrc_of(hdr_t h);
    logic [7:0] s;
    s = h.id + h.len + h.crc[7:0] + h.crc[15:8];
    return (s ^ LRC_XOR) + 8'h01; // [RQ2]
  endfunction

  function automatic id_class_t class_of(logic [7:0] id);
    if (id <= SYS_MAX) return CLS_SYSTEM; // [RQ4]
    if (id <= STATE_MAX) return CLS_STATE;
    return CLS_CONFIG;
  endfunction
endpackage

// ### rtl/nav_crc_byte.sv
/*
 * One-byte step of the payload CRC, purely combinational.
 * Assumes the caller holds the running value in its own register.
 */
`timescale 1ns/10ps
`default_nettype none
module nav_crc_byte (
  // running value and next byte
  input wire logic [15:0] crc_in,
  input wire logic [7:0] data,
  // value after the byte
  output logic [15:0] crc_out
);
  import nav_pkg::*;

  logic [15:0] stage [0:8];
  assign stage[0] = crc_in ^ {data, 8'h00};
  // msb first, no reflection, no final xor [RQ19]
  for (genvar b = 0; b < 8; b++) begin : g_bit
    assign stage[b+1] = stage[b][15] ? ((stage[b] << 1) ^ CRC_POLY)
                                     : (stage[b] << 1);
  end
  assign crc_out = stage[8];
endmodule
`default_nettype wire

// ### rtl/nav_packet_framer.sv
/*
 * Packet framer and deframer: scans the received byte stream for headers,
 * checks payload CRC, queues requests and acknowledgements, runs the
 * periodic output schedule and frames outgoing packets.
 * Assumes byte-wide link ports synchronous to clock and an application
 * that supplies payloads and verdicts on the source and result ports.
 */
`timescale 1ns/10ps
`default_nettype none
module nav_packet_framer #(
  parameter int unsigned PERIOD_CYC = nav_pkg::PERIOD_CYCLES,
  parameter logic [7:0] SYS_STATE_ID = nav_pkg::SYS_STATE_ID_DEF,
  parameter logic [7:0] RAW_SENSOR_ID = nav_pkg::RAW_SENSOR_ID_DEF
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // received bytes
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  // transmitted bytes
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [7:0] tx_data,
  // deframed packets to the application
  output logic pay_valid,
  output logic [7:0] pay_data,
  output logic pkt_done,
  output logic pkt_good,
  output nav_pkg::hdr_t pkt_hdr,
  // verdicts from the application
  input wire logic res_valid,
  output logic res_ready,
  input wire logic res_ext,
  input wire nav_pkg::ack_t res_ack,
  // payload source
  input wire logic periodic_on,
  output logic tov_strobe,
  output logic src_req,
  output logic [7:0] src_id,
  input wire logic src_valid,
  output logic src_ready,
  input wire logic [7:0] src_data,
  input wire logic src_last
);
  import nav_pkg::*;

  typedef enum {RX_SCAN, RX_BODY, RX_CHECK} rx_state_t;
  typedef enum {TX_IDLE, TX_FETCH, TX_CALC, TX_SEND} tx_state_t;

  function automatic logic [8:0] first_set(logic [255:0] v);
    logic [8:0] r;
    r = 9'h000;
    for (int i = 255; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b1, 8'(i)};
      end
    end
    return r;
  endfunction

  // receive side
  rx_state_t rx_state_r;
  logic [7:0] win_r [0:3];
  logic [2:0] fill_r;
  hdr_t hdr_r;
  logic [7:0] rx_cnt_r;
  logic [15:0] rx_crc_r, rx_crc_nxt;
  logic [255:0] req_tmp_r;
  hdr_t cand;
  logic cand_ok, chk, good, crc_ack;

  assign cand.id = win_r[1];
  assign cand.len = win_r[2];
  assign cand.crc = {rx_data, win_r[3]}; // [RQ13]
  // a start is only where the check byte fits the next four bytes [RQ3]
  assign cand_ok = (rx_state_r == RX_SCAN) && rx_valid && (fill_r == 3'd4)
                   && (lrc_of(cand) == win_r[0]);
  assign chk = (rx_state_r == RX_CHECK);
  assign good = (rx_crc_r == hdr_r.crc);

  nav_crc_byte u_rx_crc (
    .crc_in(rx_crc_r),
    .data(rx_data),
    .crc_out(rx_crc_nxt)
  );

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      fill_r <= 3'd0;
      for (int i = 0; i < 4; i++) begin
        win_r[i] <= 8'h00;
      end
    end else if (rx_state_r == RX_SCAN && rx_valid) begin
      if (cand_ok) begin
        fill_r <= 3'd0;
      end else begin
        // oldest byte falls out: scanning resumes one byte later [RQ20]
        win_r[0] <= win_r[1];
        win_r[1] <= win_r[2];
        win_r[2] <= win_r[3];
        win_r[3] <= rx_data;
        fill_r <= (fill_r == 3'd4) ? 3'd4 : fill_r + 3'd1;
      end
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rx_state_r <= RX_SCAN;
      hdr_r <= '0;
      rx_cnt_r <= 8'h00;
      rx_crc_r <= CRC_INIT;
    end else begin
      unique case (rx_state_r)
        RX_SCAN: if (cand_ok) begin
          hdr_r <= cand; // [RQ1]
          rx_cnt_r <= 8'h00;
          rx_crc_r <= CRC_INIT; // [RQ6]
          rx_state_r <= (cand.len == 8'h00) ? RX_CHECK : RX_BODY;
        end
        RX_BODY: if (rx_valid) begin
          rx_crc_r <= rx_crc_nxt;
          rx_cnt_r <= rx_cnt_r + 8'h01;
          // length counts payload bytes only [RQ5]
          if (rx_cnt_r == hdr_r.len - 8'h01) begin
            rx_state_r <= RX_CHECK;
          end
        end
        RX_CHECK: rx_state_r <= RX_SCAN;
      endcase
    end
  end

  // requested ids are held aside until the payload crc proves them [RQ16]
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      req_tmp_r <= '0;
    end else if (cand_ok) begin
      req_tmp_r <= '0;
    end else if (rx_state_r == RX_BODY && rx_valid && hdr_r.id == REQ_ID
                 && rx_data >= STATE_MIN) begin
      req_tmp_r[rx_data] <= 1'b1; // [RQ7]
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pay_valid <= 1'b0;
      pay_data <= 8'h00;
      pkt_done <= 1'b0;
      pkt_good <= 1'b0;
      pkt_hdr <= '0;
    end else begin
      pay_valid <= (rx_state_r == RX_BODY) && rx_valid;
      pay_data <= rx_data;
      pkt_done <= chk;
      pkt_good <= chk && good; // [RQ20]
      if (chk) begin
        pkt_hdr <= hdr_r;
      end
    end
  end

  // acknowledgement slot
  logic ack_pend_r, take_ack;
  ack_t ack_r;

  assign crc_ack = chk && !good && class_of(hdr_r.id) == CLS_CONFIG
                   && !ack_pend_r;
  assign res_ready = !ack_pend_r && !crc_ack;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ack_pend_r <= 1'b0;
      ack_r <= '0;
    end else begin
      if (take_ack) begin
        ack_pend_r <= 1'b0;
      end
      if (crc_ack) begin
        ack_pend_r <= 1'b1; // [RQ20]
        ack_r <= '{id: hdr_r.id, crc: hdr_r.crc, code: RES_CRC};
      end else if (res_valid && res_ready) begin
        // configuration always answered; external data only on failure
        if (!res_ext || res_ack.code != RES_OK) begin // [RQ8] [RQ9]
          ack_pend_r <= 1'b1;
          ack_r <= res_ack;
        end
      end
    end
  end

  // periodic schedule
  logic [31:0] tick_cnt_r;
  logic tick;
  assign tick = periodic_on && (tick_cnt_r == 32'(PERIOD_CYC - 1));

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      tick_cnt_r <= 32'h0;
      tov_strobe <= 1'b0;
    end else begin
      tick_cnt_r <= (!periodic_on || tick) ? 32'h0 : tick_cnt_r + 32'h1;
      // application freezes one sample time for the whole sequence [RQ12]
      tov_strobe <= tick;
    end
  end

  // transmit side
  tx_state_t tx_state_r;
  logic [255:0] due_r, req_r;
  logic [8:0] due_pick, req_pick, tx_idx_r;
  logic [7:0] buf_r [0:255];
  logic [7:0] tx_len_r, cur_id_r;
  logic [15:0] tx_crc_r, tx_crc_nxt;
  hdr_t tx_hdr_r;
  logic [7:0] hdr_lrc;

  assign due_pick = first_set(due_r);
  assign req_pick = first_set(req_r);
  assign take_ack = (tx_state_r == TX_IDLE) && ack_pend_r;
  assign src_ready = (tx_state_r == TX_FETCH);
  assign tx_valid = (tx_state_r == TX_SEND);
  assign hdr_lrc = lrc_of(tx_hdr_r);

  nav_crc_byte u_tx_crc (
    .crc_in(tx_crc_r),
    .data(buf_r[tx_idx_r[7:0]]),
    .crc_out(tx_crc_nxt)
  );

  function automatic logic [7:0] byte_at(logic [8:0] i);
    unique case (i)
      9'(OFS_LRC): return hdr_lrc;
      9'(OFS_ID): return tx_hdr_r.id;
      9'(OFS_LEN): return tx_hdr_r.len;
      9'(OFS_CRC_LO): return tx_hdr_r.crc[7:0]; // [RQ13]
      9'(OFS_CRC_HI): return tx_hdr_r.crc[15:8];
      default: return buf_r[8'(i - 9'(HDR_BYTES))];
    endcase
  endfunction

  // payload buffer: the crc leads the payload, so it must be whole first
  always_ff @(posedge clock) begin
    if (take_ack) begin
      buf_r[0] <= ack_r.id; // [RQ17]
      buf_r[1] <= ack_r.crc[7:0];
      buf_r[2] <= ack_r.crc[15:8];
      buf_r[3] <= ack_r.code;
    end else if (tx_state_r == TX_FETCH && src_valid) begin
      buf_r[tx_idx_r[7:0]] <= src_data;
    end
  end

  // pending bitmaps; a set in the same cycle as a clear wins
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      due_r <= '0;
      req_r <= '0;
    end else begin
      if (tx_state_r == TX_IDLE && !ack_pend_r) begin
        if (due_pick[8]) begin
          due_r[due_pick[7:0]] <= 1'b0;
        end else if (req_pick[8]) begin
          req_r[req_pick[7:0]] <= 1'b0;
        end
      end
      if (tick) begin
        due_r[SYS_STATE_ID] <= 1'b1; // [RQ10]
        due_r[RAW_SENSOR_ID] <= 1'b1;
      end
      if (chk && good && hdr_r.id == REQ_ID) begin
        for (int i = 0; i < 256; i++) begin
          if (req_tmp_r[i]) begin
            req_r[i] <= 1'b1; // [RQ7]
          end
        end
      end
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      tx_state_r <= TX_IDLE;
      tx_idx_r <= 9'h000;
      tx_len_r <= 8'h00;
      cur_id_r <= 8'h00;
      tx_crc_r <= CRC_INIT;
      tx_hdr_r <= '0;
      tx_data <= 8'h00;
      src_req <= 1'b0;
      src_id <= 8'h00;
    end else begin
      src_req <= 1'b0;
      unique case (tx_state_r)
        TX_IDLE: begin
          tx_idx_r <= 9'h000;
          tx_crc_r <= CRC_INIT;
          if (ack_pend_r) begin
            cur_id_r <= ACK_ID; // [RQ17]
            tx_len_r <= ACK_LEN;
            tx_state_r <= TX_CALC;
          end else if (due_pick[8] || req_pick[8]) begin
            // lowest due id first, so a sequence leaves in id order [RQ11]
            cur_id_r <= due_pick[8] ? due_pick[7:0] : req_pick[7:0];
            src_id <= due_pick[8] ? due_pick[7:0] : req_pick[7:0];
            src_req <= 1'b1;
            tx_state_r <= TX_FETCH;
          end
        end
        TX_FETCH: if (src_valid) begin
          tx_idx_r <= tx_idx_r + 9'h001;
          if (src_last || tx_idx_r == 9'(MAX_PAYLOAD - 1)) begin
            tx_len_r <= tx_idx_r[7:0] + 8'h01;
            tx_idx_r <= 9'h000;
            tx_state_r <= TX_CALC;
          end
        end
        TX_CALC: begin
          if (tx_idx_r == {1'b0, tx_len_r}) begin
            tx_hdr_r <= '{id: cur_id_r, len: tx_len_r, crc: tx_crc_r};
            tx_idx_r <= 9'h000;
            tx_data <= lrc_of('{id: cur_id_r, len: tx_len_r,
                                crc: tx_crc_r}); // [RQ2]
            tx_state_r <= TX_SEND;
          end else begin
            tx_crc_r <= tx_crc_nxt; // [RQ6]
            tx_idx_r <= tx_idx_r + 9'h001;
          end
        end
        TX_SEND: if (tx_ready) begin
          if (tx_idx_r == {1'b0, tx_hdr_r.len} + 9'(HDR_BYTES - 1)) begin
            tx_state_r <= TX_IDLE;
          end else begin
            tx_idx_r <= tx_idx_r + 9'h001;
            tx_data <= byte_at(tx_idx_r + 9'h001); // [RQ1]
          end
        end
      endcase
    end
  end

  lrc_first_a: assert property (@(posedge clock) disable iff (reset)
    tx_valid && tx_idx_r == 9'h000 |-> tx_data == lrc_of(tx_hdr_r)) // [RQ2]
    else $error("first byte out is not the header check byte");
  hdr_order_a: assert property (@(posedge clock) disable iff (reset)
    tx_valid && tx_ready && tx_idx_r == 9'h000
    |=> tx_valid && tx_idx_r == 9'h001 && tx_data == tx_hdr_r.id) // [RQ1]
    else $error("identifier does not follow the check byte");
  crc_lsb_a: assert property (@(posedge clock) disable iff (reset)
    tx_valid && tx_idx_r == 9'h003 |-> tx_data == tx_hdr_r.crc[7:0]) // [RQ13]
    else $error("crc low byte not at offset three");
  scan_lock_a: assert property (@(posedge clock) disable iff (reset)
    cand_ok |=> rx_state_r != RX_SCAN && hdr_r == $past(cand)) // [RQ3]
    else $error("valid header not locked");
  scan_slip_a: assert property (@(posedge clock) disable iff (reset)
    rx_state_r == RX_SCAN && rx_valid && fill_r == 3'd4 && !cand_ok
    |=> rx_state_r == RX_SCAN && fill_r == 3'd4
        && win_r[3] == $past(rx_data)) // [RQ20]
    else $error("scan did not slip by one byte");
  crc_ack_a: assert property (@(posedge clock) disable iff (reset)
    crc_ack |=> ack_pend_r && ack_r.code == RES_CRC) // [RQ20]
    else $error("bad config crc not acknowledged");
  ext_quiet_a: assert property (@(posedge clock) disable iff (reset)
    res_valid && res_ready && res_ext && res_ack.code == RES_OK
    |=> !ack_pend_r) // [RQ9]
    else $error("positive ack sent for external data");
  ack_frame_a: assert property (@(posedge clock) disable iff (reset)
    take_ack |=> tx_state_r == TX_CALC && tx_len_r == ACK_LEN
                 && cur_id_r == ACK_ID ##[1:5] tx_valid) // [RQ17]
    else $error("acknowledgement not framed as four byte id zero");
  tick_due_a: assert property (@(posedge clock) disable iff (reset)
    tick |=> due_r[SYS_STATE_ID] && due_r[RAW_SENSOR_ID]
             && tov_strobe) // [RQ10]
    else $error("periodic packets not scheduled on tick");
  id_order_a: assert property (@(posedge clock) disable iff (reset)
    tx_state_r == TX_IDLE && !ack_pend_r && due_pick[8] && !tick
    |=> src_req && (due_r & ((256'h1 << src_id) - 256'h1)) == '0) // [RQ11]
    else $error("due packet skipped a lower identifier");
  req_commit_a: assert property (@(posedge clock) disable iff (reset)
    chk && good && hdr_r.id == REQ_ID
    |=> (req_r & $past(req_tmp_r)) == $past(req_tmp_r)) // [RQ16]
    else $error("requested identifiers not queued");
endmodule
`default_nettype wire

// ### bench/nav_host_model.sv
/*
 * Host end of the serial link: frames packets, sends them byte by byte
 * and paces the bytes it accepts from the device.
 * Assumes byte-wide link signals sampled on the rising clock edge.
 */
`timescale 1ns/10ps
`default_nettype none
module nav_host_model (
  // clock
  input wire logic clock,
  // link towards the device
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic tx_ready,
  // pacing
  input wire logic slow
);
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_ready = 1'b0;
  end
  // a slow host takes about one byte in four, a prompt one three in four;
  // either rate stands in for a link baud that keeps up with the output
  always @(posedge clock) begin
    tx_ready <= slow ? ($urandom % 4 == 0) : ($urandom % 4 != 0);
  end
  function automatic logic [15:0] crc16(input logic [7:0] b[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (b[i]) begin
      c = c ^ {b[i], 8'h00};
      for (int k = 0; k < 8; k++) begin
        c = c[15] ? {c[14:0], 1'b0} ^ 16'h1021 : {c[14:0], 1'b0};
      end
    end
    return c;
  endfunction
  function automatic logic [7:0] lrc(input logic [7:0] id,
    input logic [7:0] len, input logic [15:0] c);
    logic [7:0] s;
    s = id + len + c[7:0] + c[15:8];
    return (s ^ 8'hff) + 8'h01;
  endfunction
  // bad flips the lowest bit of the crc field so that the payload check fails
  function automatic void frame(input logic [7:0] id,
    input logic [7:0] pl[$], input logic bad, output logic [7:0] f[$]);
    logic [15:0] c;
    c = crc16(pl) ^ {15'h0, bad};
    f = '{lrc(id, 8'(pl.size()), c), id, 8'(pl.size()), c[7:0], c[15:8]};
    f = {f, pl};
  endfunction
  task automatic send(input logic [7:0] f[$]);
    foreach (f[i]) begin
      @(posedge clock);
      rx_valid <= 1'b1;
      rx_data <= f[i];
    end
    @(posedge clock);
    rx_valid <= 1'b0;
    // an idle line must not look like a repeat of the last byte
    rx_data <= ~f[f.size() - 1];
    repeat (2) @(posedge clock);
  endtask
endmodule
`default_nettype wire

// ### bench/tb.sv
/*
 * Self-checking bench for the packet framer: host model on the link,
 * application behaviour for the source and verdict ports.
 * Assumes the framer is built with a short output period.
 */
`timescale 1ns/10ps
`default_nettype none
module tb;
  import nav_pkg::*;
  localparam int PER = 200;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic rx_valid, tx_valid, tx_ready, pay_valid, pkt_done, pkt_good;
  logic res_ready, tov_strobe, src_req, src_ready;
  logic [7:0] rx_data, tx_data, pay_data, src_id;
  logic [7:0] src_data = 8'h00;
  logic res_valid = 1'b0, res_ext = 1'b0, periodic_on = 1'b0;
  logic src_valid = 1'b0, src_last = 1'b0, slow = 1'b0, tov_seen = 1'b0;
  hdr_t pkt_hdr;
  ack_t res_ack = '0;
  logic [7:0] exp_pay[$], exp_tx[$], exp_src[$];
  logic [32:0] exp_done[$];
  int err_count = 0, check_count = 0;
  always #2.5 clock = ~clock;
  nav_host_model host (.clock(clock), .rx_valid(rx_valid),
    .rx_data(rx_data), .tx_ready(tx_ready), .slow(slow));
  nav_packet_framer #(.PERIOD_CYC(PER)) uut (.clock(clock), .reset(reset),
    .rx_valid(rx_valid), .rx_data(rx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_data(tx_data), .pay_valid(pay_valid),
    .pay_data(pay_data), .pkt_done(pkt_done), .pkt_good(pkt_good),
    .pkt_hdr(pkt_hdr), .res_valid(res_valid), .res_ready(res_ready),
    .res_ext(res_ext), .res_ack(res_ack), .periodic_on(periodic_on),
    .tov_strobe(tov_strobe), .src_req(src_req), .src_id(src_id),
    .src_valid(src_valid), .src_ready(src_ready), .src_data(src_data),
    .src_last(src_last));
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic timeout();
    err_count++;
    $display("timeout at %0t", $time);
    wrap_up();
  endtask
  task automatic wait_hi(ref logic s);
    int n;
    n = 0;
    @(negedge clock);
    while (s !== 1'b1) begin
      n++;
      if (n > 3000) timeout();
      @(negedge clock);
    end
  endtask
  task automatic drain();
    int n;
    n = 0;
    while (exp_pay.size() + exp_tx.size() + exp_src.size() > 0
      || exp_done.size() > 0) begin
      @(posedge clock);
      n++;
      if (n > 8000) timeout();
    end
    repeat (30) @(posedge clock);
  endtask
  task automatic rx_pkt(input logic [7:0] id, input logic [7:0] pl[$],
    input logic bad, output logic [7:0] f[$]);
    host.frame(id, pl, bad, f);
    exp_pay = {exp_pay, pl};
    exp_done.push_back({~bad, f[1], f[2], f[4], f[3]});
  endtask
  task automatic ack_exp(input logic [7:0] f[$], input logic [7:0] code);
    logic [7:0] a[$];
    host.frame(ACK_ID, '{f[1], f[3], f[4], code}, 1'b0, a);
    exp_tx = {exp_tx, a};
  endtask
  task automatic verdict(input logic ext, input ack_t a);
    @(posedge clock);
    res_valid <= 1'b1;
    res_ext <= ext;
    res_ack <= a;
    wait_hi(res_ready);
    @(posedge clock);
    res_valid <= 1'b0;
  endtask
  // application side: supplies a short random payload per request
  task automatic serve(input logic [7:0] id);
    logic [7:0] pl[$];
    logic [7:0] f[$];
    check(id, exp_src.size() ? exp_src.pop_front() : 9'h1ff);
    if (id == SYS_STATE_ID_DEF) begin
      check(tov_seen, 1'b1);
      tov_seen = 1'b0;
    end
    repeat (1 + $urandom % 6) pl.push_back(8'($urandom));
    host.frame(id, pl, 1'b0, f);
    exp_tx = {exp_tx, f};
    @(posedge clock);
    foreach (pl[i]) begin
      src_valid <= 1'b1;
      src_data <= pl[i];
      src_last <= (i == pl.size() - 1);
      wait_hi(src_ready);
      @(posedge clock);
    end
    src_valid <= 1'b0;
    src_last <= 1'b0;
  endtask
  // outputs are looked at mid-cycle, where they have settled
  always @(negedge clock) begin
    if (reset === 1'b0) begin
      if (pay_valid === 1'b1)
        check(pay_data, exp_pay.size() ? exp_pay.pop_front() : 9'h1ff);
      if (pkt_done === 1'b1)
        check({pkt_good, pkt_hdr}, exp_done.size() ? exp_done.pop_front()
          : 34'h3_ffff_ffff);
      if (tx_valid === 1'b1 && tx_ready === 1'b1)
        check(tx_data, exp_tx.size() ? exp_tx.pop_front() : 9'h1ff);
    end
  end
  always @(negedge clock) begin
    if (tov_strobe === 1'b1) tov_seen = 1'b1;
    if (reset === 1'b0 && src_req === 1'b1) serve(src_id);
  end
  initial begin
    logic [7:0] pl[$];
    logic [7:0] f[$];
    logic [7:0] id, j, c;
    void'($urandom(32'h919b2690));
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    // a stray byte ahead of empty, full and random payloads
    for (int k = 0; k < 3; k++) begin
      pl = {};
      repeat (k == 0 ? 0 : k == 1 ? 255 : 1 + $urandom % 8)
        pl.push_back(8'($urandom));
      id = 8'(20 + $urandom % 160);
      rx_pkt(id, pl, 1'b0, f);
      j = host.lrc(f[0], f[1], {f[3], f[2]}) + 8'h01;
      host.send('{j});
      host.send(f);
    end
    drain();
    $display("test rx_scan done");
    // bad crc: state packet dropped silently, config packet refused
    for (int k = 0; k < 2; k++) begin
      pl = '{8'($urandom), 8'($urandom), 8'($urandom)};
      rx_pkt(k ? 8'hbe : 8'h3c, pl, 1'b1, f);
      if (k) ack_exp(f, RES_CRC);
      host.send(f);
    end
    drain();
    $display("test bad_crc done");
    // system id 5 in the list is not requestable
    exp_src = '{8'h1e, 8'h28, 8'hc8};
    rx_pkt(REQ_ID, '{8'hc8, 8'h05, 8'h28, 8'h1e}, 1'b0, f);
    host.send(f);
    drain();
    $display("test request done");
    // every result code on config packets, then external data packets
    for (int k = 0; k < 9; k++) begin
      slow <= k[0];
      pl = '{8'($urandom), 8'($urandom)};
      rx_pkt(k < 7 ? 8'(180 + k) : 8'h2c, pl, 1'b0, f);
      host.send(f);
      drain();
      c = k < 7 ? 8'(k) : k == 7 ? RES_OK : RES_SIZE;
      if (k != 7) ack_exp(f, c);
      verdict(k > 6, {f[1], f[4], f[3], c});
      drain();
    end
    $display("test verdict done");
    exp_src = '{SYS_STATE_ID_DEF, RAW_SENSOR_ID_DEF,
      SYS_STATE_ID_DEF, RAW_SENSOR_ID_DEF};
    @(posedge clock);
    periodic_on <= 1'b1;
    // two ticks land at PER and 2*PER after the enable rises
    repeat (PER * 2 + PER * 3 / 4) @(posedge clock);
    periodic_on <= 1'b0;
    drain();
    $display("test periodic done");
    wrap_up();
  end
endmodule
`default_nettype wire
